// *** booth_mac_defines.vh ***
// Constants for the Booth multiply-accumulate unit
`ifndef BOOTH_MAC_DEFINES_VH
`define BOOTH_MAC_DEFINES_VH
`define PC_REG_IDX      4'hF
`define PC_OFS_NEAR     32'h00000008
`define PC_OFS_FAR      32'h0000000C
`define PC_FIELD_MASK   32'h03FFFFFC
`define FLAG_N_BIT      31
`define FLAG_Z_BIT      30
`define FLAG_C_BIT      29
`define FLAG_V_BIT      28
`define BOOTH_STEPS     5'h10
`define WORD_ZERO       32'h00000000
`endif

// *** booth_multiply_accumulate.v ***
// Booth radix-4 multiply and multiply-accumulate unit
// Overview of operation
// [RULE1] Executes only when condition is true; otherwise nothing changes.
// [RULE2] Result is the low 32 bits of a 32 by 32 product.
// [RULE3] Multiplier is recoded two bits per step, Booth style.
// [RULE4] Plain form: destination gets multiplicand times multiplier; addend ignored.
// [RULE5] Accumulate form adds the addend, truncated to 32 bits.
// [RULE6] Same result for signed or unsigned operands; no signedness control.
// [RULE7] Destination equal multiplicand: plain form gives zero, accumulate undefined.
// [RULE8] Destination program counter: no write; flags scrambled if flag update.
// [RULE9] All other register combinations, including shared registers, are correct.
// [RULE10] Flags change only when the flag-update bit is set.
// [RULE11] Negative flag is result bit 31; zero flag set when result is zero.
// [RULE12] Overflow flag unchanged; carry flag unspecified.
// [RULE13] Program counter as multiplier: address plus 8, flag bits zeroed.
// [RULE14] Program counter as addend: address plus 8 with status flags.
// [RULE15] Program counter as multiplicand: address plus 12 with status flags.
// [RULE16] Flag bits occupy positions 0, 1 and 26 to 31.
// [RULE17] N, Z, C, V sit at bits 31, 30, 29, 28.
// [RULE18] Program counter field is 24 bits wide between the flags.
// [RULE19] Start request, multicycle iteration, one-cycle done pulse.
`timescale 1ns/1ps
`include "booth_mac_defines.vh"
module booth_multiply_accumulate #(
  parameter W = 32
) (
  input  wire         mclk,
  input  wire         rst,
  input  wire         start,
  input  wire         cond_pass,
  input  wire         accumulate_op,
  input  wire         set_flags,
  input  wire [3:0]   dest_idx,
  input  wire [3:0]   multiplicand_idx,
  input  wire [3:0]   multiplier_idx,
  input  wire [3:0]   addend_idx,
  input  wire [W-1:0] multiplicand_reg,
  input  wire [W-1:0] multiplier_reg,
  input  wire [W-1:0] addend_reg,
  input  wire [W-1:0] instr_addr,
  input  wire [W-1:0] status_flags_word,
  output wire         busy,
  output reg          done,
  output reg          result_we,
  output reg  [3:0]   result_idx,
  output reg  [W-1:0] result,
  output reg          flags_we,
  output reg  [3:0]   flags_nzcv
);
  localparam S_IDLE = 3'h1;
  localparam S_RUN  = 3'h2;
  localparam S_DONE = 3'h4;

  reg [2:0]   state_r;
  reg [W-1:0] acc_r;
  reg [W-1:0] mcand_r;
  reg [W:0]   mplier_r;
  reg [4:0]   step_r;
  reg         zero_force_r;
  reg         pc_dest_r;
  reg         flags_r;
  reg [3:0]   dest_r;
  reg [3:0]   old_flags_r;

  // Next values of the iteration registers
  reg [2:0]   state_nxt;
  reg [W-1:0] acc_nxt;
  reg [W-1:0] mcand_nxt;
  reg [W:0]   mplier_nxt;
  reg [4:0]   step_nxt;

  // Program counter operand forms
  wire         pc_as_mcand  = (multiplicand_idx == `PC_REG_IDX);
  wire         pc_as_mplier = (multiplier_idx == `PC_REG_IDX);
  wire         pc_as_addend = (addend_idx == `PC_REG_IDX);
  wire [W-1:0] psr_flags = status_flags_word & ~`PC_FIELD_MASK; // RULE16
  wire [W-1:0] pc_near   = (instr_addr + `PC_OFS_NEAR) & `PC_FIELD_MASK; // RULE18
  wire [W-1:0] pc_far    = (instr_addr + `PC_OFS_FAR) & `PC_FIELD_MASK;
  wire [W-1:0] op_m = pc_as_mcand ?
                      (pc_far | psr_flags) : multiplicand_reg; // RULE15
  wire [W-1:0] op_s = pc_as_mplier ?
                      pc_near : multiplier_reg; // RULE13
  wire [W-1:0] op_n = pc_as_addend ?
                      (pc_near | psr_flags) : addend_reg; // RULE14
  // RULE4 RULE5: addend seeds accumulator only in accumulate form
  wire [W-1:0] acc_seed = accumulate_op ? op_n : `WORD_ZERO;

  // RULE3: radix-4 Booth digit from three multiplier bits
  // Digit is zero, one or two times the multiplicand, negated when the digit is negative
  wire         digit_neg = mplier_r[2] && !(mplier_r[1] && mplier_r[0]);
  wire         digit_one = mplier_r[1] ^ mplier_r[0];
  wire         digit_two = (mplier_r[2:0] == 3'h3) || (mplier_r[2:0] == 3'h4);
  reg  [W-1:0] booth_mag;
  reg  [W-1:0] booth_term;
  always @* begin
    booth_mag = `WORD_ZERO;
    if (digit_two) begin
      booth_mag = {mcand_r[W-2:0], 1'b0};
    end else if (digit_one) begin
      booth_mag = mcand_r;
    end
    if (digit_neg) begin
      booth_term = ~booth_mag + 1'b1;
    end else begin
      booth_term = booth_mag;
    end
  end

  assign busy = (state_r != S_IDLE);

  // Request accepted only while idle; a false condition ends at once
  wire accept    = start && !busy;
  wire launch    = accept && cond_pass; // RULE1
  wire skip      = accept && !cond_pass; // RULE1
  wire last_step = (step_r == `BOOTH_STEPS - 5'h01);
  wire finish    = (state_r == S_DONE);

  // Plain form with destination equal multiplicand gives zero
  wire [W-1:0] final_result = zero_force_r ? `WORD_ZERO : acc_r; // RULE7
  wire         n_flag       = final_result[`FLAG_N_BIT]; // RULE11
  wire         z_flag       = (final_result == `WORD_ZERO); // RULE11

  // Next state and iteration datapath
  always @* begin
    state_nxt  = state_r;
    acc_nxt    = acc_r;
    mcand_nxt  = mcand_r;
    mplier_nxt = mplier_r;
    step_nxt   = step_r;
    case (state_r)
      S_IDLE: begin
        if (launch) begin
          state_nxt  = S_RUN;
          acc_nxt    = acc_seed; // RULE4 RULE5
          mcand_nxt  = op_m; // RULE6 RULE9
          mplier_nxt = {op_s, 1'b0};
          step_nxt   = 5'h00;
        end
      end
      S_RUN: begin
        // Sum kept to 32 bits; multiplicand moves up two places per step
        acc_nxt    = acc_r + booth_term; // RULE2
        mcand_nxt  = {mcand_r[W-3:0], 2'b00};
        mplier_nxt = {2'b00, mplier_r[W:2]}; // RULE3
        step_nxt   = step_r + 5'h01;
        if (last_step) begin
          state_nxt = S_DONE;
        end
      end
      S_DONE: begin
        state_nxt = S_IDLE;
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  // State and iteration registers
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r  <= S_IDLE;
      acc_r    <= `WORD_ZERO;
      mcand_r  <= `WORD_ZERO;
      mplier_r <= {(W+1){1'b0}};
      step_r   <= 5'h00;
    end else begin
      state_r  <= state_nxt;
      acc_r    <= acc_nxt;
      mcand_r  <= mcand_nxt;
      mplier_r <= mplier_nxt;
      step_r   <= step_nxt;
    end
  end

  // Command fields captured at launch, held for write-back
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      zero_force_r <= 1'b0;
      pc_dest_r    <= 1'b0;
      flags_r      <= 1'b0;
      dest_r       <= 4'h0;
      old_flags_r  <= 4'h0;
    end else if (launch) begin
      zero_force_r <= (dest_idx == multiplicand_idx) && !accumulate_op; // RULE7
      pc_dest_r    <= (dest_idx == `PC_REG_IDX); // RULE8
      flags_r      <= set_flags; // RULE10
      dest_r       <= dest_idx;
      old_flags_r  <= status_flags_word[`FLAG_N_BIT:`FLAG_V_BIT]; // RULE12
    end
  end

  // Write-back strobes, one cycle each
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      done      <= 1'b0;
      result_we <= 1'b0;
      flags_we  <= 1'b0;
    end else begin
      done      <= finish || skip; // RULE1 RULE19
      result_we <= finish && !pc_dest_r; // RULE8
      flags_we  <= finish && flags_r; // RULE10
    end
  end

  // Write-back words, held until the next completion
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      result_idx <= 4'h0;
      result     <= `WORD_ZERO;
      flags_nzcv <= 4'h0;
    end else if (finish) begin
      result_idx <= dest_r;
      result     <= final_result; // RULE2
      if (pc_dest_r) begin
        flags_nzcv <= acc_r[`FLAG_N_BIT:`FLAG_V_BIT]; // RULE8
      end else begin
        // Carry left at its old value
        flags_nzcv <= {n_flag, z_flag, old_flags_r[1], old_flags_r[0]}; // RULE11 RULE12 RULE17
      end
    end
  end
endmodule

// *** booth_mac_monitor.sv ***
// Port checker for the multiply-accumulate unit
`timescale 1ns/1ps
module booth_mac_monitor #(
  parameter W = 32
) (
  input wire         mclk,
  input wire         rst,
  input wire         start,
  input wire         busy,
  input wire         cond_pass,
  input wire         set_flags,
  input wire         done,
  input wire         result_we,
  input wire         flags_we,
  input wire [3:0]   dest_idx,
  input wire [3:0]   result_idx,
  input wire [3:0]   flags_nzcv,
  input wire [W-1:0] result,
  input wire [W-1:0] status_flags_word
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  reg  [6:0] cap_r;
  wire       go = start && !busy;
  always @(posedge mclk or posedge rst)
    if (rst) cap_r <= 7'h00;
    else if (go) cap_r <= {cond_pass, set_flags, dest_idx, status_flags_word[28]};
  AST_SKIP: assert property (go && !cond_pass |=>
    done && !result_we && !flags_we) else $error("skip");
  AST_LAT: assert property (go && cond_pass |-> ##18 done) else $error("late");
  AST_NOPC: assert property (result_we |-> done && result_idx != 4'hF) else $error("pc");
  AST_NZ: assert property (flags_we && result_we |->
    flags_nzcv[3:2] == {result[W-1], result == {W{1'b0}}}) else $error("nz");
  AST_V: assert property (flags_we && result_we |->
    flags_nzcv[0] == cap_r[0]) else $error("v");
  AST_SF: assert property (done |->
    flags_we == (cap_r[6] && cap_r[5])) else $error("sf");
  AST_WE: assert property (done |->
    result_we == (cap_r[6] && cap_r[4:1] != 4'hF)) else $error("we");
  AST_HOLD: assert property ($changed(result) |-> done && !busy) else $error("hold");
  C_WR: cover property (done && result_we);
  C_NOWR: cover property (done && !result_we);
  C_PCF: cover property (flags_we && !result_we);
endmodule

// *** core_regfile_model.sv ***
// Core register file model feeding the unit's operand ports
`timescale 1ns/1ps
module core_regfile_model (
  input wire         mclk, result_we,
  input wire [3:0]   result_idx, multiplicand_idx, multiplier_idx, addend_idx,
  input wire [31:0]  result,
  output wire [31:0] multiplicand_reg, multiplier_reg, addend_reg);
  reg [31:0] regs [0:15];
  always @(posedge mclk) if (result_we) regs[result_idx] <= result;
  assign multiplicand_reg = regs[multiplicand_idx];
  assign multiplier_reg   = regs[multiplier_idx];
  assign addend_reg       = regs[addend_idx];
endmodule

// *** tb_top.sv ***
// Self-checking bench for the multiply-accumulate unit
`timescale 1ns/1ps
`include "booth_mac_defines.vh"
module tb_top;
  localparam M = `PC_FIELD_MASK;
  reg         mclk = 0, rst = 1, start = 0, cond_pass = 0, accumulate_op = 0, set_flags = 0;
  reg  [3:0]  dest_idx = 0, multiplicand_idx = 0, multiplier_idx = 0, addend_idx = 0;
  reg  [31:0] instr_addr = 0, status_flags_word = 0, a, b, c, q[$];
  reg  [3:0]  qf[$], qd[$];
  wire [31:0] multiplicand_reg, multiplier_reg, addend_reg, result;
  wire [3:0]  result_idx, flags_nzcv;
  wire        busy, done, result_we, flags_we;
  integer     seed = 26, n_errors = 0, cmp_count = 0, cyc = 0, i;
  always #12.5 mclk = ~mclk;
  core_regfile_model rf_u (.*);
  booth_multiply_accumulate dut_u (.*);
  task chk(input [31:0] e, x);
    cmp_count = cmp_count + 1;
    if (x !== e) begin
      n_errors = n_errors + 1;
      $display("Error at %0t: expected %h got %h", $time, e, x);
    end
  endtask
  task chk_flags(input [3:0] e, x);
    cmp_count = cmp_count + 1;
    if (x !== e) begin
      n_errors = n_errors + 1;
      $display("Error at %0t: flags expected %h got %h", $time, e, x);
    end
  endtask
  task chk_idx(input [3:0] e, x);
    cmp_count = cmp_count + 1;
    if (x !== e) begin
      n_errors = n_errors + 1;
      $display("Error at %0t: index expected %h got %h", $time, e, x);
    end
  endtask
  task end_of_test;
    $display("Compares %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task rnd;
    @(posedge mclk) #2;
    a = $random(seed);
    b = $random(seed);
    c = $random(seed);
    instr_addr = $random(seed);
    status_flags_word = $random(seed);
  endtask
  task op(input cp, ac, sf, input [3:0] d, m, s, n, input [31:0] e, input ex);
    rf_u.regs[1] = a;
    rf_u.regs[2] = b;
    rf_u.regs[3] = c;
    {cond_pass, accumulate_op, set_flags} = {cp, ac, sf};
    {dest_idx, multiplicand_idx, multiplier_idx, addend_idx} = {d, m, s, n};
    if (ex) begin
      q.push_back(e);
      qd.push_back(d);
      if (sf) qf.push_back({e[31], e == 32'h0, status_flags_word[29:28]});
    end
    start = 1;
    @(posedge mclk) #2 start = 0;
    repeat (20) @(posedge mclk);
    $display("Test ended, dest %h", d);
  endtask
  always @(negedge mclk)
    if (done === 1'b1 && result_we === 1'b1) begin
      chk(q.size() ? q.pop_front() : ~result, result);
      chk_idx(qd.size() ? qd.pop_front() : ~result_idx, result_idx);
      if (flags_we === 1'b1)
        chk_flags(qf.size() ? qf.pop_front() : ~flags_nzcv, flags_nzcv);
    end
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 1000) begin
      n_errors = n_errors + 1;
      end_of_test;
    end
  end
  initial begin
    repeat (10) @(posedge mclk);
    #2 rst = 0;
    for (i = 0; i < 6; i = i + 1) begin
      rnd;
      op(1, i[0], i[1], 4, 1, 2, i[0] ? 3 : 0, a * b + (i[0] ? c : 0), 1);
    end
    rnd;
    op(1, 1, 1, 2, 1, 2, 2, a * b + b, 1);
    rnd;
    op(1, 0, 1, 1, 1, 2, 0, 32'h0, 1);
    rnd;
    op(1, 0, 1, 4, 1, 4'hF, 0, a * ((instr_addr + 8) & M), 1);
    rnd;
    op(1, 1, 0, 4, 1, 2, 4'hF, a * b + (((instr_addr + 8) & M) | (status_flags_word & ~M)), 1);
    rnd;
    op(1, 0, 0, 4, 4'hF, 2, 0, (((instr_addr + 12) & M) | (status_flags_word & ~M)) * b, 1);
    rnd;
    op(1, 0, 1, 4'hF, 1, 2, 0, 0, 0);
    rnd;
    op(0, 1, 1, 4, 1, 2, 3, 0, 0);
    chk(0, q.size());
    chk(0, qf.size());
    end_of_test;
  end
endmodule
bind booth_multiply_accumulate booth_mac_monitor #(.W(W)) mon_u (.*);
